// *** design/ats_top.sv ***
// Transmit error flags, interrupt and current slot counter.
// Assumes event inputs are one-cycle pulses from logic on clk, except
// the frame sync pin which is synchronised here.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns

// Functional notes
// - Clock-fail flag, status bit 2, sets on a clock-check error.
// - Interrupt is high while clock-fail flag and its enable are set.
// - Early-sync flag, status bit 1, sets on a premature frame sync.
// - Interrupt is high while early-sync flag and its enable are set.
// - Underrun flag, bit 0, sets when a move finds no new buffer word.
// - Interrupt is high while underrun flag and its enable are set.
// - Flags stay set until a one is written; a zero does nothing.
// - Slot count is read-only in slot register bits 9-0, range 0..383.
// - Slot count holds 383 in reset so the first count is 0.
// - Frames hold at most 32 slots, S/PDIF blocks run up to 383.
// - Slot register bits 31-10 read zero and writes are ignored.
// - Error summary bit reads the OR of all four error flags.
// - Slot-parity status bit mirrors the slot count LSB.
module ats_top (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [7:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [31:0]         regRdata,
   input  wire logic                txFrameSync,
   input  wire logic                txSlotTick,
   input  wire logic                txBufferWrite,
   input  wire logic                txShiftLoad,
   input  wire logic                clkCheckErr,
   input  wire logic                txDmaErr,
   input  wire logic                spdifTransmitMode,
   output logic                     txInterrupt,
   output logic      [9:0]          txSlotCount
);

   // Register port and decoded writes
   ats_pkg::ats_req_s    req;
   logic        wrStatus;
   logic        wrIntEn;
   logic        wrFrameLen;
   logic [3:0]  wrFlags;

   // Event flags and interrupt
   ats_pkg::ats_events_s ev;
   logic [3:0]  setVec;
   logic [3:0]  flags;
   logic [3:0]  clrVec;
   logic [3:0]  intEn_q;
   logic [3:0]  pending;

   // Slot counter
   logic [9:0]  frameLen_q;
   logic [9:0]  slot_q;
   logic [9:0]  slot_d;
   logic [9:0]  lastSlot;
   logic        atLast;
   logic        started_q;

   // Frame sync pin
   logic        syncMeta_q;
   logic        syncSync_q;
   logic        syncPrev_q;
   logic        syncRise;

   // Underrun tracking
   logic        bufFresh_q;

   // Read path
   logic [31:0] statusWord;
   logic [31:0] intEnWord;
   logic [31:0] slotWord;
   logic [31:0] frameLenWord;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   assign req.addr  = regAddr;
   assign req.wdata = regWdata;
   assign req.wr    = regWr;
   assign req.rd    = regRd;

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------
   assign wrStatus   = req.wr && (req.addr == ats_pkg::TX_STATUS_OFS);
   assign wrIntEn    = req.wr && (req.addr == ats_pkg::TX_INT_EN_OFS);
   assign wrFrameLen = req.wr && (req.addr == ats_pkg::TX_FRAME_LEN_OFS);

   // Write data gathered into flag order: dma, clock, sync, underrun
   assign wrFlags = {req.wdata[ats_pkg::DMA_ERR_BIT],
                     req.wdata[ats_pkg::CLK_FAIL_BIT],
                     req.wdata[ats_pkg::EARLY_SYNC_BIT],
                     req.wdata[ats_pkg::UNDERRUN_BIT]};

   // ----------------------------------------------------------------
   // Frame sync synchroniser and edge detect
   // ----------------------------------------------------------------
   // The pin is asynchronous: two flops before any logic, a third for
   // the edge; all reset low like the idle pin, so no false edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncMeta_q <= 1'b0;
         syncSync_q <= 1'b0;
         syncPrev_q <= 1'b0;
      end else begin
         syncMeta_q <= txFrameSync;
         syncSync_q <= syncMeta_q;
         syncPrev_q <= syncSync_q;
      end
   end

   assign syncRise = syncSync_q & ~syncPrev_q;

   // ----------------------------------------------------------------
   // Slot counter
   // ----------------------------------------------------------------
   // S/PDIF blocks use the full 384-slot range, TDM the programmed length up to 32 slots
   // A zero frame length is taken as a one-slot frame
   always_comb begin
      if (spdifTransmitMode) begin
         lastSlot = ats_pkg::SLOT_MAX;
      end else if (frameLen_q == 10'h000) begin
         lastSlot = 10'h000;
      end else if (frameLen_q > ats_pkg::TDM_MAX_SLOTS) begin
         lastSlot = ats_pkg::TDM_MAX_SLOTS - 10'h001;
      end else begin
         lastSlot = frameLen_q - 10'h001;
      end
   end

   assign atLast = (slot_q >= lastSlot);

   always_comb begin
      slot_d = slot_q;
      if (syncRise) begin
         slot_d = 10'h000;
      end else if (txSlotTick) begin
         if (atLast) begin
            slot_d = 10'h000;
         end else begin
            slot_d = slot_q + 10'h001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_q <= ats_pkg::SLOT_RESET;
      end else begin
         slot_q <= slot_d;
      end
   end

   // ----------------------------------------------------------------
   // Frame start marker
   // ----------------------------------------------------------------
   // Marks that at least one frame has begun, so the slot count before the
   // first frame sync after reset cannot make that sync look early
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         started_q <= 1'b0;
      end else if (syncRise) begin
         started_q <= 1'b1;
      end
   end

   assign txSlotCount = slot_q;

   // ----------------------------------------------------------------
   // Underrun tracking
   // ----------------------------------------------------------------
   // A load consumes the buffer even when a word is written beside it:
   // that word goes out with this load, so the next load needs another
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bufFresh_q <= 1'b0;
      end else if (txShiftLoad) begin
         bufFresh_q <= 1'b0;
      end else if (txBufferWrite) begin
         bufFresh_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Error events
   // ----------------------------------------------------------------
   // Early sync: a new frame sync before the last slot of the frame
   assign ev.earlySync = syncRise & started_q & ~atLast;
   assign ev.clkFail   = clkCheckErr;
   assign ev.underrun  = txShiftLoad & ~bufFresh_q
                         & ~txBufferWrite;
   assign ev.dmaErr    = txDmaErr;

   assign setVec = {ev.dmaErr, ev.clkFail, ev.earlySync, ev.underrun};

   // Write-one-to-clear of the status register
   always_comb begin
      clrVec = 4'h0;
      if (wrStatus) begin
         clrVec = wrFlags;
      end
   end

   // ----------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------
   ats_flag_bank u_flags (
      .clk    (clk),
      .rst    (rst),
      .setVec (setVec),
      .clrVec (clrVec),
      .flags  (flags)
   );

   // ----------------------------------------------------------------
   // Interrupt enable and frame length registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intEn_q <= ats_pkg::INT_EN_RESET;
      end else if (wrIntEn) begin
         intEn_q <= wrFlags;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frameLen_q <= ats_pkg::FRAME_LEN_RST;
      end else if (wrFrameLen) begin
         frameLen_q <= req.wdata[9:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   // One level output, high while any enabled flag is set
   assign pending = flags & intEn_q;

   assign txInterrupt = pending[2]
                      | pending[1]
                      | pending[0]
                      | pending[3];

   // ----------------------------------------------------------------
   // Register words
   // ----------------------------------------------------------------
   // Enable readback has the same layout as the status flags
   always_comb begin
      intEnWord = 32'h0000_0000;
      intEnWord[ats_pkg::UNDERRUN_BIT]   = intEn_q[0];
      intEnWord[ats_pkg::EARLY_SYNC_BIT] = intEn_q[1];
      intEnWord[ats_pkg::CLK_FAIL_BIT]   = intEn_q[2];
      intEnWord[ats_pkg::DMA_ERR_BIT]    = intEn_q[3];
   end

   // Reserved upper bits of the slot register always read zero
   assign slotWord     = {22'h0, slot_q};
   assign frameLenWord = {22'h0, frameLen_q};

   // Status word: sticky flags, slot parity and error summary
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[ats_pkg::UNDERRUN_BIT]   = flags[0];
      statusWord[ats_pkg::EARLY_SYNC_BIT] = flags[1];
      statusWord[ats_pkg::CLK_FAIL_BIT]   = flags[2];
      statusWord[ats_pkg::PARITY_BIT]     = slot_q[0];
      statusWord[ats_pkg::DMA_ERR_BIT]    = flags[3];
      statusWord[ats_pkg::ERR_SUM_BIT]    = |flags;
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (req.addr)
         ats_pkg::TX_STATUS_OFS: begin
            rdata_d = statusWord;
         end
         ats_pkg::TX_SLOT_OFS: begin
            rdata_d = slotWord;
         end
         ats_pkg::TX_INT_EN_OFS: begin
            rdata_d = intEnWord;
         end
         ats_pkg::TX_FRAME_LEN_OFS: begin
            rdata_d = frameLenWord;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // Read data stand for the one cycle after the strobe, else zero
   assign regRdata = rdata_q;

endmodule

// *** design/ats_pkg.sv ***
// Package for the transmit status and slot counter block.
// Assumes a plain register port with read data one cycle after the strobe.
package ats_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] TX_STATUS_OFS    = 8'hc0;
   localparam logic [7:0] TX_SLOT_OFS      = 8'hc4;
   localparam logic [7:0] TX_INT_EN_OFS    = 8'hcc;
   localparam logic [7:0] TX_FRAME_LEN_OFS = 8'hd0;

   // ----------------------------------------------------------------
   // Status field positions
   // ----------------------------------------------------------------
   localparam int UNDERRUN_BIT   = 0;
   localparam int EARLY_SYNC_BIT = 1;
   localparam int CLK_FAIL_BIT   = 2;
   localparam int PARITY_BIT     = 3;
   localparam int DMA_ERR_BIT    = 7;
   localparam int ERR_SUM_BIT    = 8;

   // ----------------------------------------------------------------
   // Slot counter
   // ----------------------------------------------------------------
   localparam int         SLOT_W        = 10;
   localparam logic [9:0] SLOT_RESET    = 10'h17f;
   localparam logic [9:0] SLOT_MAX      = 10'h17f;
   localparam logic [9:0] TDM_MAX_SLOTS = 10'h020;
   localparam logic [9:0] FRAME_LEN_RST = 10'h002;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] FLAGS_RESET  = 4'h0;
   localparam logic [3:0] INT_EN_RESET = 4'h0;

   // Error events from the transmitter in one cycle
   typedef struct packed {
      logic dmaErr;
      logic clkFail;
      logic earlySync;
      logic underrun;
   } ats_events_s;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ats_req_s;

endpackage

// *** design/ats_flag_bank.sv ***
// Sticky event flags cleared by writing one.
// Assumes events and clear mask arrive on clk; set wins over clear.
`timescale 1ns/1ns
module ats_flag_bank (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] setVec,
   input  wire logic [3:0] clrVec,
   output logic      [3:0] flags
);

   logic [3:0] flags_q;

   // ----------------------------------------------------------------
   // One flip-flop per flag
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_flag
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               flags_q[i] <= ats_pkg::FLAGS_RESET[i];
            end else if (setVec[i]) begin
               flags_q[i] <= 1'b1;
            end else if (clrVec[i]) begin
               flags_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flags_q;

endmodule

// *** sim/ats_top_sva.sv ***
// Checker for the transmit status and slot counter block.
// Assumes it is bound to ats_top and sees only its ports.
`timescale 1ns/1ns
module ats_top_sva (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  regAddr,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        txFrameSync,
   input wire logic        txSlotTick,
   input wire logic        spdifTransmitMode,
   input wire logic        txInterrupt,
   input wire logic [9:0]  txSlotCount
);
   logic [2:0] quiet;

   // Cycles since the sync pin was last high, so ticks are not masked
   always_ff @(posedge clk or posedge rst)
      if (rst)
         quiet <= 3'h0;
      else if (txFrameSync)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_rdStatus;
      regRd && regAddr == ats_pkg::TX_STATUS_OFS;
   endsequence
   sequence s_tick;
      txSlotTick && spdifTransmitMode && quiet == 3'h7;
   endsequence

   property p_rstSlot;
      $past(rst) |-> txSlotCount == ats_pkg::SLOT_RESET;
   endproperty
   property p_range;
      txSlotCount <= ats_pkg::SLOT_MAX;
   endproperty
   property p_step;
      s_tick ##0 txSlotCount != ats_pkg::SLOT_MAX
         |=> txSlotCount == $past(txSlotCount) + 10'h1;
   endproperty
   property p_wrap;
      s_tick ##0 txSlotCount == ats_pkg::SLOT_MAX |=> txSlotCount == 10'h0;
   endproperty
   property p_slotRead;
      regRd && regAddr == ats_pkg::TX_SLOT_OFS
         |=> regRdata == {22'h0, $past(txSlotCount)};
   endproperty
   property p_sum;
      s_rdStatus |=> regRdata[8] == (|{regRdata[7], regRdata[2:0]});
   endproperty
   property p_parity;
      s_rdStatus |=> regRdata[3] == $past(txSlotCount[0]);
   endproperty
   property p_irqHold;
      txInterrupt && !regWr |=> txInterrupt;
   endproperty

   a_rstSlot: assert property (p_rstSlot)
      else $error("slot count not at reset value");
   a_range: assert property (p_range)
      else $error("slot count out of range");
   a_step: assert property (p_step)
      else $error("slot count did not step");
   a_wrap: assert property (p_wrap)
      else $error("slot count did not wrap");
   a_slotRead: assert property (p_slotRead)
      else $error("slot register read wrong");
   a_sum: assert property (p_sum)
      else $error("error summary wrong");
   a_parity: assert property (p_parity)
      else $error("slot parity wrong");
   a_irqHold: assert property (p_irqHold)
      else $error("interrupt dropped without a write");
endmodule

bind ats_top ats_top_sva u_sva (.clk, .rst, .regAddr, .regWr, .regRd,
   .regRdata, .txFrameSync, .txSlotTick, .spdifTransmitMode,
   .txInterrupt, .txSlotCount);

// *** sim/ats_link_model.sv ***
// Far-end frame timing: one 16-cycle period per slot, two slots a frame.
// Assumes the bench clock; sync idles low outside frames.
`timescale 1ns/1ns
module ats_link_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic early,
   output logic      txFrameSync,
   output logic      txSlotTick
);
   logic [3:0] phase_q;
   logic       slot_q;

   // Early mode never leaves slot 0, so every sync after the first comes too soon
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= 4'h0;
         slot_q <= 1'b0;
      end else if (!run) begin
         phase_q <= 4'h0;
         slot_q <= 1'b0;
      end else begin
         phase_q <= phase_q + 4'h1;
         if (phase_q == 4'hf)
            slot_q <= !slot_q && !early;
      end
   end

   assign txFrameSync = run && !slot_q && phase_q < 4'h4;
   assign txSlotTick = run && slot_q && phase_q == 4'h0;
endmodule

// *** sim/ats_top_tb.sv ***
// Bench for the transmit status and slot counter block.
// Assumes ats_top, the checker bind and the link model are compiled.
`timescale 1ns/1ns
module ats_top_tb;
   typedef struct packed {
      logic [3:0]  ev;
      logic [31:0] en;
      logic [31:0] st;
      logic        irq;
   } ats_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr = 8'h0;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0, regRd = 1'b0, tbTick = 1'b0;
   logic        bufWr = 1'b0, shLoad = 1'b0, ckErr = 1'b0, dmaErr = 1'b0;
   logic        spdif = 1'b0, run = 1'b0, early = 1'b0;
   logic        txFrameSync, txSlotTick, mTick, txInterrupt;
   logic [31:0] regRdata, d;
   logic [9:0]  txSlotCount;
   int          error_cnt = 0;
   int          cmp_count = 0;
   ats_row_s    rows [6] = '{
      '{4'h4, 32'h4, 32'h104, 1'b1}, '{4'h4, 32'h0, 32'h104, 1'b0},
      '{4'h2, 32'h2, 32'h102, 1'b1}, '{4'h1, 32'h1, 32'h101, 1'b1},
      '{4'h8, 32'h80, 32'h180, 1'b1}, '{4'h1, 32'h6, 32'h101, 1'b0}};

   always #25 clk = ~clk;
   assign txSlotTick = mTick | tbTick;

   ats_top uut (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .txFrameSync, .txSlotTick, .txBufferWrite(bufWr),
      .txShiftLoad(shLoad), .clkCheckErr(ckErr), .txDmaErr(dmaErr),
      .spdifTransmitMode(spdif), .txInterrupt, .txSlotCount);
   ats_link_model link (.clk, .rst, .run, .early, .txFrameSync,
      .txSlotTick(mTick));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic tick();
      @(posedge clk);
      tbTick <= 1'b1;
      @(posedge clk);
      tbTick <= 1'b0;
   endtask
   // Underrun: a fresh load, then a second load with no new word
   task automatic fire(input logic [3:0] ev);
      @(posedge clk);
      ckErr <= ev[2];
      dmaErr <= ev[3];
      bufWr <= ev[0];
      shLoad <= ev[0];
      @(posedge clk);
      ckErr <= 1'b0;
      dmaErr <= 1'b0;
      bufWr <= 1'b0;
      @(posedge clk);
      shLoad <= 1'b0;
      early <= ev[1];
      run <= ev[1];
      repeat (40) @(posedge clk);
      run <= 1'b0;
      early <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      chk({22'h0, txSlotCount}, 32'h17f);
      rst <= 1'b0;
      rd(ats_pkg::TX_SLOT_OFS);
      chk(d, 32'h17f);
      rd(ats_pkg::TX_STATUS_OFS);
      chk(d, 32'h8);
      rd(8'h00);
      chk(d, 32'h0);
      wr(ats_pkg::TX_SLOT_OFS, 32'h0000_03ff);
      rd(ats_pkg::TX_SLOT_OFS);
      chk(d, 32'h17f);
      foreach (rows[i]) begin
         wr(ats_pkg::TX_INT_EN_OFS, rows[i].en);
         fire(rows[i].ev);
         rd(ats_pkg::TX_STATUS_OFS);
         chk(d & 32'hfffffff7, rows[i].st);
         chk({31'h0, txInterrupt}, {31'h0, rows[i].irq});
         wr(ats_pkg::TX_STATUS_OFS, 32'h0);
         rd(ats_pkg::TX_STATUS_OFS);
         chk(d & 32'hfffffff7, rows[i].st);
         wr(ats_pkg::TX_STATUS_OFS, 32'h87);
         rd(ats_pkg::TX_STATUS_OFS);
         chk(d & 32'hfffffff7, 32'h0);
         chk({31'h0, txInterrupt}, 32'h0);
      end
      tick();
      run <= 1'b1;
      repeat (64) @(posedge clk);
      run <= 1'b0;
      bufWr <= 1'b1;
      @(posedge clk);
      bufWr <= 1'b0;
      shLoad <= 1'b1;
      @(posedge clk);
      shLoad <= 1'b0;
      rd(ats_pkg::TX_STATUS_OFS);
      chk(d & 32'h3, 32'h0);
      spdif <= 1'b1;
      for (int k = 0; k < 400 && txSlotCount !== 10'h17f; k++) begin
         tick();
         #1;
      end
      chk({22'h0, txSlotCount}, 32'h17f);
      tick();
      #1 chk({22'h0, txSlotCount}, 32'h0);
      // TDM frames are capped at 32 slots whatever length is asked for
      wr(ats_pkg::TX_FRAME_LEN_OFS, 32'h40);
      spdif <= 1'b0;
      rd(ats_pkg::TX_FRAME_LEN_OFS);
      chk(d, 32'h40);
      repeat (31) tick();
      #1 chk({22'h0, txSlotCount}, 32'h1f);
      tick();
      #1 chk({22'h0, txSlotCount}, 32'h0);
      // Reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk({22'h0, txSlotCount}, 32'h17f);
      rd(ats_pkg::TX_STATUS_OFS);
      chk(d, 32'h8);
      chk({31'h0, txInterrupt}, 32'h0);
      end_of_test();
   end
endmodule
